// file: common/rx_align_map.vh
// constants and register map of the receive word aligner
// Functional notes
// - after reset release, scan for pattern or complement
// - raise lock after programmed good sync count
// - drop lock after programmed count of bad groups
// - stay unlocked until good sync count again
// - loss-of-sync bad count programmable 1 to 64
// - good run per decrement programmable 1 to 256
// - flag run of equal bits reaching threshold
// - run-length flag held at least two cycles
// - threshold 4..128 step 4, 5..160 step 5
// - bit-slip mode reversal mirrors output word
// - report number of bits slipped for alignment
`ifndef RX_ALIGN_MAP_VH
`define RX_ALIGN_MAP_VH
`define RA_ADDR_W        4
`define RA_OFF_CTRL      4'h0
`define RA_OFF_PATTERN   4'h1
`define RA_OFF_SYNC      4'h2
`define RA_OFF_RUN       4'h3
`define RA_OFF_STATUS    4'h4
`define RA_OFF_IRQ_STAT  4'h5
`define RA_OFF_IRQ_MASK  4'h6
// control fields
`define RA_CTRL_MODE10   0
`define RA_CTRL_BITSLIP  1
`define RA_CTRL_REVERSE  2
`define RA_CTRL_SLIPREQ  3
// sync field positions
`define RA_SYNC_ACQ_LSB  0
`define RA_SYNC_LOSS_LSB 8
`define RA_SYNC_GOOD_LSB 16
// irq bits
`define RA_IRQ_LOCK      0
`define RA_IRQ_UNLOCK    1
`define RA_IRQ_RLV       2
// reset values, run flag hold and threshold steps
`define RA_CTRL_RST      32'h0000_0000
`define RA_PATTERN_RST   32'h0000_017C
`define RA_SYNC_RST      32'h0000_0403
`define RA_RUN_RST       32'h0000_0000
`define RA_RLV_HOLD      2
`define RA_RUN_STEP8     4
`define RA_RUN_STEP10    5
`endif

// file: src/rx_run_check.v
// run-length violation detector for one parallel word
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_map.vh"
module rx_run_check #(
  parameter W = 10
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_word,
  input  wire         i_mode10,
  input  wire [4:0]   i_thr_sel,
  output reg          o_rlv
);
  reg  [7:0] run_r;
  reg        last_r;
  reg  [1:0] hold_r;
  reg  [7:0] run_nxt;
  reg        bit_v;
  reg        hit;
  wire [7:0] limit;
  wire [31:0] limit_full;
  wire [31:0] hold_full;
  integer    k;

  // threshold is (sel+1) steps of 4 or 5 by width
  assign limit_full = i_mode10 ? ({27'h0, i_thr_sel} + 32'd1) * `RA_RUN_STEP10
                               : ({27'h0, i_thr_sel} + 32'd1) * `RA_RUN_STEP8;
  assign limit      = limit_full[7:0]; // at most 160, fits
  assign hold_full  = `RA_RLV_HOLD;

  // walk the word lsb first, counting equal bits
  always @* begin
    run_nxt = run_r;
    bit_v   = last_r;
    hit     = 1'b0;
    for (k = 0; k < W; k = k + 1) begin
      if (k < 8 || i_mode10) begin
        if (i_word[k] != bit_v)
          run_nxt = 8'd1;
        else if (run_nxt != 8'hff)
          run_nxt = run_nxt + 8'd1;
        bit_v = i_word[k];
        if (run_nxt >= limit)
          hit = 1'b1;
      end
    end
  end

  // flag stretched to the minimum hold
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_r  <= 8'h00;
      last_r <= 1'b0;
      hold_r <= 2'b00;
      o_rlv  <= 1'b0;
    end else begin
      run_r  <= run_nxt;
      last_r <= bit_v;
      if (hit)
        hold_r <= hold_full[1:0];
      else if (hold_r != 2'b00)
        hold_r <= hold_r - 2'b01;
      o_rlv <= hit | (hold_r > 2'b01);
    end
  end
endmodule
`default_nettype wire

// file: src/rx_word_aligner_sync.v
// receive word aligner with sync state machine and avalon registers
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_map.vh"
module rx_word_aligner_sync #(
  parameter W = 10
) (
  input  wire         I_REF_CLK,
  input  wire         I_RST,
  input  wire [W-1:0] I_RX_DATA,
  input  wire [3:0]   I_AVS_ADDRESS,
  input  wire         I_AVS_READ,
  input  wire         I_AVS_WRITE,
  input  wire [31:0]  I_AVS_WRITEDATA,
  output reg  [31:0]  O_AVS_READDATA,
  output reg          O_AVS_WAITREQUEST,
  output reg  [W-1:0] O_RX_WORD,
  output reg          O_SYNC_LOCK,
  output reg          O_RUN_VIOL,
  output reg  [3:0]   O_SLIP_COUNT,
  output reg          O_IRQ
);
  localparam ST_HUNT  = 2'b00;
  localparam ST_LOCK  = 2'b01;

  reg  [31:0]  ctrl_r;
  reg  [31:0]  pattern_r;
  reg  [31:0]  sync_r;
  reg  [31:0]  run_cfg_r;
  reg  [2:0]   irq_stat_r;
  reg  [2:0]   irq_mask_r;
  reg          ack_r;
  reg  [1:0]   state_r;
  reg  [7:0]   acq_cnt_r;
  reg  [6:0]   err_cnt_r;
  reg  [8:0]   good_cnt_r;
  reg  [3:0]   slip_r;
  reg  [W-1:0] prev_r;
  reg  [W-1:0] aligned_r;
  reg          rlv_d_r;
  reg          lock_d_r;
  reg  [2*W-1:0] cat;
  reg  [W-1:0] shifted;
  reg  [W-1:0] pat_w;
  reg  [W-1:0] mask_w;
  reg  [W-1:0] mirror;
  reg  [3:0]   slip_nxt;
  reg  [3:0]   i;
  reg          found;
  wire         is_sync;
  wire         mode10;
  wire         bitslip;
  wire         rlv;
  wire         rd_stat;
  wire [7:0]   acq_need;
  wire [6:0]   loss_need;
  wire [8:0]   good_need;
  wire [3:0]   wmax;
  integer      j;

  assign mode10    = ctrl_r[`RA_CTRL_MODE10];
  assign bitslip   = ctrl_r[`RA_CTRL_BITSLIP];
  assign wmax      = mode10 ? 4'd9 : 4'd7;
  // programmed counts stored minus one
  assign acq_need  = sync_r[`RA_SYNC_ACQ_LSB +: 8];
  assign loss_need = {1'b0, sync_r[`RA_SYNC_LOSS_LSB +: 6]} + 7'd1;
  assign good_need = {1'b0, sync_r[`RA_SYNC_GOOD_LSB +: 8]} + 9'd1;
  assign rd_stat   = ack_r & I_AVS_READ & (I_AVS_ADDRESS == `RA_OFF_IRQ_STAT);

  // width-masked alignment pattern
  always @* begin
    mask_w = mode10 ? {W{1'b1}} : {{(W-8){1'b0}}, 8'hff};
    pat_w  = pattern_r[W-1:0] & mask_w;
  end

  // search every offset for pattern or complement
  always @* begin
    cat      = {I_RX_DATA, prev_r};
    slip_nxt = slip_r;
    found    = 1'b0;
    for (j = W - 1; j >= 0; j = j - 1) begin
      i = j[3:0];
      if (i <= wmax && !bitslip && state_r == ST_HUNT) begin
        shifted = cat[j +: W] & mask_w;
        if (shifted == pat_w || shifted == (~pat_w & mask_w)) begin
          slip_nxt = i;
          found    = 1'b1;
        end
      end
    end
    if (bitslip)
      slip_nxt = slip_r;
    shifted = cat[slip_r +: W] & mask_w;
  end

  assign is_sync = (shifted == pat_w) || (shifted == (~pat_w & mask_w));

  // bit reversal of the output word in bit-slip mode
  always @* begin
    mirror = shifted;
    if (bitslip && ctrl_r[`RA_CTRL_REVERSE]) begin
      for (j = 0; j < W; j = j + 1) begin
        if (j <= wmax)
          mirror[j] = shifted[wmax - j[3:0]];
      end
    end
  end

  rx_run_check #(
    .W (W)
  ) u_run (
    .i_clk     (I_REF_CLK),
    .i_rst     (I_RST),
    .i_word    (I_RX_DATA),
    .i_mode10  (mode10),
    .i_thr_sel (run_cfg_r[4:0]),
    .o_rlv     (rlv)
  );

  // data path, slip offset and sync state machine
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      prev_r      <= {W{1'b0}};
      aligned_r   <= {W{1'b0}};
      slip_r      <= 4'h0;
      state_r     <= ST_HUNT;
      acq_cnt_r   <= 8'h00;
      err_cnt_r   <= 7'h00;
      good_cnt_r  <= 9'h000;
      O_RX_WORD   <= {W{1'b0}};
      O_SYNC_LOCK <= 1'b0;
      O_SLIP_COUNT <= 4'h0;
      O_RUN_VIOL  <= 1'b0;
    end else begin
      prev_r       <= I_RX_DATA;
      aligned_r    <= mirror;
      O_RX_WORD    <= aligned_r;
      O_RUN_VIOL   <= rlv;
      O_SLIP_COUNT <= slip_r;
      // manual slip advances one position per request
      if (bitslip && ack_r && I_AVS_WRITE && I_AVS_ADDRESS == `RA_OFF_CTRL &&
          I_AVS_WRITEDATA[`RA_CTRL_SLIPREQ])
        slip_r <= (slip_r >= wmax) ? 4'h0 : slip_r + 4'h1;
      else if (found)
        slip_r <= slip_nxt;
      case (state_r)
        ST_HUNT: begin
          O_SYNC_LOCK <= 1'b0;
          if (bitslip) begin
            acq_cnt_r <= 8'h00;
          end else if (is_sync || found) begin
            if (acq_cnt_r >= acq_need) begin
              state_r     <= ST_LOCK;
              O_SYNC_LOCK <= 1'b1;
              acq_cnt_r   <= 8'h00;
              err_cnt_r   <= 7'h00;
              good_cnt_r  <= 9'h000;
            end else begin
              acq_cnt_r <= acq_cnt_r + 8'h01;
            end
          end
        end
        ST_LOCK: begin
          if (bitslip) begin
            state_r <= ST_HUNT;
            O_SYNC_LOCK <= 1'b0;
          end else if (!is_sync && rlv) begin
            good_cnt_r <= 9'h000;
            if (err_cnt_r + 7'd1 >= loss_need) begin
              state_r     <= ST_HUNT;
              O_SYNC_LOCK <= 1'b0;
              acq_cnt_r   <= 8'h00;
            end else begin
              err_cnt_r <= err_cnt_r + 7'd1;
            end
          end else if (err_cnt_r != 7'h00) begin
            if (good_cnt_r + 9'd1 >= good_need) begin
              err_cnt_r  <= err_cnt_r - 7'd1;
              good_cnt_r <= 9'h000;
            end else begin
              good_cnt_r <= good_cnt_r + 9'd1;
            end
          end
        end
        default: begin
          state_r <= ST_HUNT;
        end
      endcase
    end
  end

  // avalon slave: one wait cycle then ack
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_r            <= `RA_CTRL_RST;
      pattern_r         <= `RA_PATTERN_RST;
      sync_r            <= `RA_SYNC_RST;
      run_cfg_r         <= `RA_RUN_RST;
      irq_mask_r        <= 3'b000;
      ack_r             <= 1'b0;
      O_AVS_READDATA    <= 32'h0000_0000;
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      ack_r             <= (I_AVS_READ | I_AVS_WRITE) & ~ack_r;
      O_AVS_WAITREQUEST <= ~((I_AVS_READ | I_AVS_WRITE) & ~ack_r);
      if (ack_r && I_AVS_WRITE) begin
        case (I_AVS_ADDRESS)
          `RA_OFF_CTRL:     ctrl_r     <= I_AVS_WRITEDATA & 32'h0000_0007;
          `RA_OFF_PATTERN:  pattern_r  <= I_AVS_WRITEDATA & 32'h0000_03ff;
          `RA_OFF_SYNC:     sync_r     <= I_AVS_WRITEDATA & 32'h00ff_3fff;
          `RA_OFF_RUN:      run_cfg_r  <= I_AVS_WRITEDATA & 32'h0000_001f;
          `RA_OFF_IRQ_MASK: irq_mask_r <= I_AVS_WRITEDATA[2:0];
          default:          ctrl_r     <= ctrl_r;
        endcase
      end
      if (!ack_r && I_AVS_READ) begin
        case (I_AVS_ADDRESS)
          `RA_OFF_CTRL:     O_AVS_READDATA <= ctrl_r;
          `RA_OFF_PATTERN:  O_AVS_READDATA <= pattern_r;
          `RA_OFF_SYNC:     O_AVS_READDATA <= sync_r;
          `RA_OFF_RUN:      O_AVS_READDATA <= run_cfg_r;
          `RA_OFF_STATUS:   O_AVS_READDATA <= {26'h0, slip_r, O_RUN_VIOL, O_SYNC_LOCK};
          `RA_OFF_IRQ_STAT: O_AVS_READDATA <= {29'h0, irq_stat_r};
          `RA_OFF_IRQ_MASK: O_AVS_READDATA <= {29'h0, irq_mask_r};
          default:          O_AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sticky events, set wins over read clear
  always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_stat_r <= 3'b000;
      rlv_d_r    <= 1'b0;
      lock_d_r   <= 1'b0;
      O_IRQ      <= 1'b0;
    end else begin
      rlv_d_r  <= O_RUN_VIOL;
      lock_d_r <= O_SYNC_LOCK;
      irq_stat_r[`RA_IRQ_LOCK] <= (irq_stat_r[`RA_IRQ_LOCK] & ~rd_stat) |
                                  (state_r == ST_HUNT && !bitslip && (is_sync || found) &&
                                   acq_cnt_r >= acq_need);
      irq_stat_r[`RA_IRQ_UNLOCK] <= (irq_stat_r[`RA_IRQ_UNLOCK] & ~rd_stat) |
                                    (lock_d_r & ~O_SYNC_LOCK); // falling lock edge
      irq_stat_r[`RA_IRQ_RLV] <= (irq_stat_r[`RA_IRQ_RLV] & ~rd_stat) |
                                 (O_RUN_VIOL & ~rlv_d_r);
      O_IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule
`default_nettype wire

// file: test/rx_align_monitor.sv
// assertion checker on the word aligner ports
`timescale 1ns/1ps
`default_nettype none
module rx_align_monitor #(
  parameter W = 10
) (
  input wire logic         I_REF_CLK,
  input wire logic         I_RST,
  input wire logic [W-1:0] I_RX_DATA,
  input wire logic         I_AVS_READ,
  input wire logic         I_AVS_WRITE,
  input wire logic [31:0]  O_AVS_READDATA,
  input wire logic         O_AVS_WAITREQUEST,
  input wire logic [W-1:0] O_RX_WORD,
  input wire logic         O_SYNC_LOCK,
  input wire logic         O_RUN_VIOL
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  logic [7:0] zrun_r;
  logic [7:0] age_r;
  // zero-word run length and cycles since last run flag
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      zrun_r <= 8'h00;
      age_r  <= 8'hFF;
    end else begin
      zrun_r <= (I_RX_DATA != '0) ? 8'h00 : zrun_r + {7'h00, zrun_r != 8'hFF};
      age_r  <= O_RUN_VIOL ? 8'h00 : age_r + {7'h00, age_r != 8'hFF};
    end
  end
  sequence s_req;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  property p_idle;
    !(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
  endproperty
  property p_rd_stand;
    !$stable(O_AVS_READDATA) |-> !O_AVS_WAITREQUEST;
  endproperty
  property p_rlv_hold;
    $rose(O_RUN_VIOL) |=> O_RUN_VIOL;
  endproperty
  property p_rlv_long;
    zrun_r == 8'd20 |-> age_r < 8'd16;
  endproperty
  property p_loss;
    $fell(O_SYNC_LOCK) |-> age_r < 8'd40;
  endproperty
  property p_quiet;
    zrun_r >= 8'd10 |-> !$rose(O_SYNC_LOCK);
  endproperty
  property p_zero_word;
    zrun_r >= 8'd5 |-> O_RX_WORD == '0;
  endproperty
  a_ack: assert property (p_ack) else $error("no single-cycle ack");
  a_idle: assert property (p_idle) else $error("ack without request");
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  a_rlv_hold: assert property (p_rlv_hold) else $error("run flag too short");
  a_rlv_long: assert property (p_rlv_long) else $error("long run not flagged");
  a_loss: assert property (p_loss) else $error("lock lost without errors");
  a_quiet: assert property (p_quiet) else $error("lock on idle zeros");
  a_zero_word: assert property (p_zero_word) else $error("zero word altered");
endmodule
bind rx_word_aligner_sync rx_align_monitor #(.W(W)) u_mon (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_RX_DATA(I_RX_DATA),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_RX_WORD(O_RX_WORD), .O_SYNC_LOCK(O_SYNC_LOCK), .O_RUN_VIOL(O_RUN_VIOL)
);
`default_nettype wire

// file: test/rx_remote_tx.sv
// remote transmitter model feeding deserialized words
`timescale 1ns/1ps
`default_nettype none
module rx_remote_tx (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic [9:0] i_pat,
  output logic [9:0]      o_word
);
  integer seed = 32'h970a_6bcb;
  initial o_word = 10'h000;
  // 0 random, 1 pattern, 2 zeros, 3 complement
  always @(posedge i_clk) begin
    case (i_mode)
      2'd0: o_word <= 10'($random(seed));
      2'd1: o_word <= i_pat;
      2'd2: o_word <= 10'h000;
      default: o_word <= ~i_pat;
    endcase
  end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the receive word aligner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst;
  logic [3:0]  ad;
  logic        rd;
  logic        we;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic        wreq;
  logic [9:0]  word;
  logic        lock;
  logic        rlv;
  logic [3:0]  slip;
  logic        irq;
  logic [1:0]  mode;
  logic [9:0]  pat;
  logic [9:0]  txw;
  logic [9:0]  w_off;
  logic [3:0]  s0;
  logic [31:0] rs;
  integer      seed;
  int          n;
  int          failures = 0;
  int          comparisons = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  rx_remote_tx u_tx (.i_clk(clk), .i_mode(mode), .i_pat(pat), .o_word(txw));
  rx_word_aligner_sync #(.W(10)) dut (
    .I_REF_CLK(clk), .I_RST(rst), .I_RX_DATA(txw), .I_AVS_ADDRESS(ad),
    .I_AVS_READ(rd), .I_AVS_WRITE(we), .I_AVS_WRITEDATA(wd),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .O_RX_WORD(word),
    .O_SYNC_LOCK(lock), .O_RUN_VIOL(rlv), .O_SLIP_COUNT(slip), .O_IRQ(irq)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    we <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k >= 50) begin
      failures++;
      conclude;
    end
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_lock(input logic v);
    n = 0;
    while (lock !== v && n < 150) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic [9:0] rev10(input logic [9:0] v);
    for (int i = 0; i < 10; i++) rev10[i] = v[9-i];
  endfunction
  // read data watcher against the oldest note
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && exp_q.size() > 0)
      check(rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // a few hundred cycles of tests, 40000-cycle limit
  initial begin
    #200000;
    failures++;
    conclude;
  end
  initial begin
    seed = 32'h970a_6bcb;
    rst = 1'b1; rd = 1'b0; we = 1'b0; ad = 4'h0; wd = 32'h0000_0000;
    mode = 2'd2; pat = 10'h17C;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdx(4'h0, 32'h0000_0000, 32'hFFFF_FFFF);
    rdx(4'h1, 32'h0000_017C, 32'hFFFF_FFFF);
    rdx(4'h2, 32'h0000_0403, 32'hFFFF_FFFF);
    rdx(4'h3, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rdx(4'hF, 32'h0000_0000, 32'hFFFF_FFFF);
    rs = ($random(seed) & 32'h00FF_3F00) | 32'h0000_0003;
    bus(1'b1, 4'h2, rs);
    rdx(4'h2, rs, 32'h00FF_3FFF);
    bus(1'b1, 4'h0, 32'h0000_0001);
    bus(1'b1, 4'h6, 32'h0000_0001);
    $display("registers done");
    for (int i = 1; i < 4; i += 2) begin
      mode <= 2'd2;
      wait_lock(1'b0);
      check({31'h0, lock}, 32'h0000_0000);
      mode <= i[1:0];
      wait_lock(1'b1);
      check({31'h0, lock}, 32'h0000_0001);
      @(posedge clk);
      check({31'h0, irq}, 32'h0000_0001);
      rdx(4'h5, 32'h0000_0001, 32'h0000_0001);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0000_0000);
    end
    mode <= 2'd2;
    wait_lock(1'b0);
    mode <= 2'd0;
    repeat (30) @(posedge clk);
    check({31'h0, lock}, 32'h0000_0000);
    $display("sync done");
    bus(1'b1, 4'h3, 32'h0000_001F);
    mode <= 2'd1;
    repeat (10) @(posedge clk);
    mode <= 2'd2;
    n = 0;
    repeat (15) begin
      @(posedge clk);
      if (rlv === 1'b1) n++;
    end
    check(n, 32'h0000_0000);
    repeat (10) begin
      @(posedge clk);
      if (rlv === 1'b1) n++;
    end
    check({31'h0, n > 0}, 32'h0000_0001);
    rdx(4'h5, 32'h0000_0004, 32'h0000_0004);
    $display("run length done");
    wait_lock(1'b0);
    pat <= rev10(10'($random(seed)));
    mode <= 2'd1;
    bus(1'b1, 4'h0, 32'h0000_0003);
    repeat (6) @(posedge clk);
    w_off = word;
    bus(1'b1, 4'h0, 32'h0000_0007);
    repeat (6) @(posedge clk);
    check({22'h0, word}, {22'h0, rev10(w_off)});
    s0 = slip;
    bus(1'b1, 4'h0, 32'h0000_000F);
    repeat (6) @(posedge clk);
    check({28'h0, slip}, {28'h0, (s0 >= 4'h9) ? 4'h0 : s0 + 4'h1});
    $display("bit slip done");
    conclude;
  end
endmodule
`default_nettype wire
